/* File: src/gpe_port.sv */
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "gpe_params.svh"

module gpe_port #(
	parameter int N_LINES = 64,
	parameter int N_IRQ   = 8,
	parameter int N_DED   = 16
) (
	// Clock, reset, enable
	input  wire logic                 REF_CLK,
	input  wire logic                 RESETN,
	input  wire logic                 CE,
	// AXI4-Lite write address
	input  wire logic [11:0]          AWADDR,
	input  wire logic                 AWVALID,
	output logic                      AWREADY,
	// AXI4-Lite write data
	input  wire logic [31:0]          WDATA,
	input  wire logic [3:0]           WSTRB,
	input  wire logic                 WVALID,
	output logic                      WREADY,
	// AXI4-Lite write response
	output logic [1:0]                BRESP,
	output logic                      BVALID,
	input  wire logic                 BREADY,
	// AXI4-Lite read
	input  wire logic [11:0]          ARADDR,
	input  wire logic                 ARVALID,
	output logic                      ARREADY,
	output logic [31:0]               RDATA,
	output logic [1:0]                RRESP,
	output logic                      RVALID,
	input  wire logic                 RREADY,
	// Pins
	input  wire logic [N_LINES-1:0]   GPIO_IN,
	output logic [N_LINES-1:0]        GPIO_OUT,
	output logic [N_LINES-1:0]        GPIO_OE,
	// Alternate function mux
	input  wire logic [N_LINES-1:0]   ALT_OUT,
	input  wire logic [N_LINES-1:0]   ALT_OE,
	output logic [N_LINES-1:0]        ALT_IN,
	output logic [N_LINES-1:0]        PIN_SEL_ALT,
	// Pad configuration, packed per pad
	output logic [N_LINES*6-1:0]      PAD_CFG,
	// Interrupts
	output logic                      CPU_INTERRUPT,
	output logic                      POWER_UNIT_INTERRUPT
);
	localparam int PW = `GPE_PAD_WIDTH;

	initial begin
		if (N_LINES != 64 || N_IRQ != 8 || N_DED != 16)
			$error("gpe_port: register map serves only 64 lines, 8 irq, 16 dedicated");
	end

	// ****************************************
	// Input synchroniser
	// ****************************************
	logic [N_LINES-1:0] in_sync;

	gpe_sync #(.WIDTH(N_LINES)) u_sync (
		.clk    (REF_CLK),
		.rst_n  (RESETN),
		.ce     (CE),
		.pin_in (GPIO_IN),
		.level  (in_sync)
	);

	// ****************************************
	// Register state
	// ****************************************
	logic [N_LINES-1:0] out_r, out_nxt;
	logic [N_LINES-1:0] oe_r, oe_nxt;
	logic [31:0]        sel_r, sel_nxt;
	logic [N_IRQ-1:0]   rise_r, rise_nxt;
	logic [N_IRQ-1:0]   fall_r, fall_nxt;
	logic [N_IRQ-1:0]   lvl_r, lvl_nxt;
	logic [N_IRQ-1:0]   stat_r, stat_nxt;
	logic [N_IRQ-1:0]   mask_r, mask_nxt;
	logic [N_IRQ-1:0]   prev_r, prev_nxt;
	logic [PW-1:0]      pad_r [N_LINES];
	logic [PW-1:0]      pad_nxt [N_LINES];

	// Bus state
	gpe_pkg::gpe_wr_state_t wst_r, wst_nxt;
	gpe_pkg::gpe_rd_state_t rst_r, rst_nxt;
	logic [11:0] awa_r, awa_nxt;
	logic        awv_r, awv_nxt;
	logic [31:0] wd_r, wd_nxt;
	logic [3:0]  ws_r, ws_nxt;
	logic        wv_r, wv_nxt;
	logic [1:0]  bresp_r, bresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0]  rresp_r, rresp_nxt;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic is_pad(input logic [11:0] a);
		return (a >= `GPE_OFS_PAD_BASE) && (a < `GPE_OFS_PAD_BASE + 12'h100);
	endfunction

	// Pad words start at the base, not at zero, so rebase before indexing
	function automatic logic [5:0] pad_idx(input logic [11:0] a);
		logic [11:0] off;
		off = a - `GPE_OFS_PAD_BASE;
		return off[7:2];
	endfunction

	// ****************************************
	// Edge and level detection
	// ****************************************
	logic [N_IRQ-1:0] rise_ev, fall_ev, ev;
	logic [N_IRQ-1:0] cur;
	assign cur     = in_sync[N_IRQ-1:0];
	assign rise_ev = cur & ~prev_r & rise_r;
	assign fall_ev = ~cur & prev_r & fall_r;
	assign ev      = rise_ev | fall_ev | (cur & lvl_r);

	// ****************************************
	// Bus handshakes
	// ****************************************
	logic wr_go, rd_go, stat_rd;
	assign AWREADY = (wst_r == gpe_pkg::GPE_WR_IDLE) && !awv_r;
	assign WREADY  = (wst_r == gpe_pkg::GPE_WR_IDLE) && !wv_r;
	assign ARREADY = (rst_r == gpe_pkg::GPE_RD_IDLE);
	assign wr_go   = awv_r && wv_r && (wst_r == gpe_pkg::GPE_WR_IDLE);
	assign rd_go   = ARVALID && ARREADY;
	assign stat_rd = rd_go && (ARADDR == `GPE_OFS_IRQ_STAT);

	always_comb begin
		wst_nxt   = wst_r;
		awa_nxt   = awa_r;
		awv_nxt   = awv_r;
		wd_nxt    = wd_r;
		ws_nxt    = ws_r;
		wv_nxt    = wv_r;
		bresp_nxt = bresp_r;
		out_nxt   = out_r;
		oe_nxt    = oe_r;
		sel_nxt   = sel_r;
		rise_nxt  = rise_r;
		fall_nxt  = fall_r;
		lvl_nxt   = lvl_r;
		mask_nxt  = mask_r;
		pad_nxt   = pad_r;
		if (AWVALID && AWREADY) begin
			awa_nxt = AWADDR;
			awv_nxt = 1'b1;
		end
		if (WVALID && WREADY) begin
			wd_nxt = WDATA;
			ws_nxt = WSTRB;
			wv_nxt = 1'b1;
		end
		case (wst_r)
			gpe_pkg::GPE_WR_IDLE: begin
				if (wr_go) begin
					awv_nxt   = 1'b0;
					wv_nxt    = 1'b0;
					wst_nxt   = gpe_pkg::GPE_WR_RESP;
					bresp_nxt = `GPE_RESP_OKAY;
					if (awa_r == `GPE_OFS_OUT_LO) begin
						out_nxt[31:0] = merge(out_r[31:0], wd_r, ws_r);
					end else if (awa_r == `GPE_OFS_OUT_HI) begin
						out_nxt[63:32] = merge(out_r[63:32], wd_r, ws_r);
					end else if (awa_r == `GPE_OFS_OE_LO) begin
						oe_nxt[31:0] = merge(oe_r[31:0], wd_r, ws_r);
					end else if (awa_r == `GPE_OFS_OE_HI) begin
						oe_nxt[63:32] = merge(oe_r[63:32], wd_r, ws_r);
					end else if (awa_r == `GPE_OFS_PINSEL_HI) begin
						sel_nxt = merge(sel_r, wd_r, ws_r);
					end else if (awa_r == `GPE_OFS_RISE_EN) begin
						if (ws_r[0]) rise_nxt = wd_r[N_IRQ-1:0];
					end else if (awa_r == `GPE_OFS_FALL_EN) begin
						if (ws_r[0]) fall_nxt = wd_r[N_IRQ-1:0];
					end else if (awa_r == `GPE_OFS_LEVEL_EN) begin
						if (ws_r[0]) lvl_nxt = wd_r[N_IRQ-1:0];
					end else if (awa_r == `GPE_OFS_IRQ_MASK) begin
						if (ws_r[0]) mask_nxt = wd_r[N_IRQ-1:0];
					end else if (awa_r == `GPE_OFS_IRQ_STAT || awa_r == `GPE_OFS_IN_LO ||
						awa_r == `GPE_OFS_IN_HI) begin
						bresp_nxt = `GPE_RESP_OKAY;
					end else if (is_pad(awa_r)) begin
						if (ws_r[0]) pad_nxt[pad_idx(awa_r)] = wd_r[PW-1:0];
					end else begin
						bresp_nxt = `GPE_RESP_SLVERR;
					end
				end
			end
			gpe_pkg::GPE_WR_RESP: begin
				if (BREADY) wst_nxt = gpe_pkg::GPE_WR_IDLE;
			end
			default: wst_nxt = gpe_pkg::GPE_WR_IDLE;
		endcase
	end

	// ****************************************
	// Read path
	// ****************************************
	always_comb begin
		rst_nxt   = rst_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		case (rst_r)
			gpe_pkg::GPE_RD_IDLE: begin
				if (rd_go) begin
					rst_nxt   = gpe_pkg::GPE_RD_RESP;
					rresp_nxt = `GPE_RESP_OKAY;
					rdata_nxt = 32'h00000000;
					if (ARADDR == `GPE_OFS_OUT_LO) begin
						rdata_nxt = out_r[31:0];
					end else if (ARADDR == `GPE_OFS_OUT_HI) begin
						rdata_nxt = out_r[63:32];
					end else if (ARADDR == `GPE_OFS_OE_LO) begin
						rdata_nxt = oe_r[31:0];
					end else if (ARADDR == `GPE_OFS_OE_HI) begin
						rdata_nxt = oe_r[63:32];
					end else if (ARADDR == `GPE_OFS_IN_LO) begin
						rdata_nxt = in_sync[31:0];
					end else if (ARADDR == `GPE_OFS_IN_HI) begin
						rdata_nxt = in_sync[63:32];
					end else if (ARADDR == `GPE_OFS_PINSEL_HI) begin
						rdata_nxt = sel_r;
					end else if (ARADDR == `GPE_OFS_RISE_EN) begin
						rdata_nxt[N_IRQ-1:0] = rise_r;
					end else if (ARADDR == `GPE_OFS_FALL_EN) begin
						rdata_nxt[N_IRQ-1:0] = fall_r;
					end else if (ARADDR == `GPE_OFS_LEVEL_EN) begin
						rdata_nxt[N_IRQ-1:0] = lvl_r;
					end else if (ARADDR == `GPE_OFS_IRQ_STAT) begin
						rdata_nxt[N_IRQ-1:0] = stat_r;
					end else if (ARADDR == `GPE_OFS_IRQ_MASK) begin
						rdata_nxt[N_IRQ-1:0] = mask_r;
					end else if (is_pad(ARADDR)) begin
						rdata_nxt[PW-1:0] = pad_r[pad_idx(ARADDR)];
					end else begin
						rresp_nxt = `GPE_RESP_SLVERR;
					end
				end
			end
			gpe_pkg::GPE_RD_RESP: begin
				if (RREADY) rst_nxt = gpe_pkg::GPE_RD_IDLE;
			end
			default: rst_nxt = gpe_pkg::GPE_RD_IDLE;
		endcase
	end

	// ****************************************
	// Interrupt status
	// ****************************************
	// A new event in the cycle of the clearing read stays set
	always_comb begin
		prev_nxt = cur;
		stat_nxt = stat_r;
		if (stat_rd) stat_nxt = '0;
		stat_nxt = stat_nxt | ev;
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			wst_r   <= gpe_pkg::GPE_WR_IDLE;
			rst_r   <= gpe_pkg::GPE_RD_IDLE;
			awa_r   <= 12'h000;
			awv_r   <= 1'b0;
			wd_r    <= 32'h00000000;
			ws_r    <= 4'h0;
			wv_r    <= 1'b0;
			bresp_r <= 2'h0;
			rdata_r <= 32'h00000000;
			rresp_r <= 2'h0;
			out_r   <= '0;
			oe_r    <= '0;
			sel_r   <= `GPE_PINSEL_RST;
			rise_r  <= '0;
			fall_r  <= '0;
			lvl_r   <= '0;
			stat_r  <= '0;
			mask_r  <= '0;
			prev_r  <= '0;
			for (int i = 0; i < N_LINES; i++) pad_r[i] <= `GPE_PAD_RST;
		end else if (CE) begin
			wst_r   <= wst_nxt;
			rst_r   <= rst_nxt;
			awa_r   <= awa_nxt;
			awv_r   <= awv_nxt;
			wd_r    <= wd_nxt;
			ws_r    <= ws_nxt;
			wv_r    <= wv_nxt;
			bresp_r <= bresp_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			out_r   <= out_nxt;
			oe_r    <= oe_nxt;
			sel_r   <= sel_nxt;
			rise_r  <= rise_nxt;
			fall_r  <= fall_nxt;
			lvl_r   <= lvl_nxt;
			stat_r  <= stat_nxt;
			mask_r  <= mask_nxt;
			prev_r  <= prev_nxt;
			pad_r   <= pad_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	logic [N_LINES-1:0] alt_sel;
	// Dedicated lines can never be handed to an alternate function
	// The select word is 32 bits, so only lines 16 to 47 can be handed over
	assign alt_sel = {{(N_LINES-N_DED-32){1'b0}}, sel_r, {N_DED{1'b0}}};

	assign GPIO_OUT    = (alt_sel & ALT_OUT) | (~alt_sel & out_r);
	assign GPIO_OE     = (alt_sel & ALT_OE) | (~alt_sel & oe_r);
	assign ALT_IN      = alt_sel & in_sync;
	assign PIN_SEL_ALT = alt_sel;

	genvar g;
	generate
		for (g = 0; g < N_LINES; g++) begin : g_pad
			assign PAD_CFG[g*PW +: PW] = pad_r[g];
		end
	endgenerate

	assign CPU_INTERRUPT        = |(stat_r & mask_r);
	assign POWER_UNIT_INTERRUPT = |(stat_r & mask_r);

	assign BVALID = (wst_r == gpe_pkg::GPE_WR_RESP);
	assign BRESP  = bresp_r;
	assign RVALID = (rst_r == gpe_pkg::GPE_RD_RESP);
	assign RDATA  = rdata_r;
	assign RRESP  = rresp_r;
endmodule

`default_nettype wire

/* File: common/gpe_params.svh */
`ifndef GPE_PARAMS_SVH
`define GPE_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define GPE_OFS_OUT_LO     12'h000
`define GPE_OFS_OUT_HI     12'h004
`define GPE_OFS_RISE_EN    12'h008
`define GPE_OFS_FALL_EN    12'h00C
`define GPE_OFS_OE_LO      12'h010
`define GPE_OFS_OE_HI      12'h014
`define GPE_OFS_IN_LO      12'h018
`define GPE_OFS_IN_HI      12'h01C
`define GPE_OFS_PINSEL_HI  12'h020
`define GPE_OFS_LEVEL_EN   12'h024
`define GPE_OFS_IRQ_STAT   12'h028
`define GPE_OFS_IRQ_MASK   12'h02C
`define GPE_OFS_PAD_BASE   12'h040

// ****************************************
// Field layout and reset values
// ****************************************
`define GPE_PAD_SLEW_BIT   0
`define GPE_PAD_SCHM_BIT   1
`define GPE_PAD_PUEN_BIT   2
`define GPE_PAD_PUP_BIT    3
`define GPE_PAD_DRV_LSB    4
`define GPE_PAD_WIDTH      6
`define GPE_PAD_RST        6'h04
`define GPE_PINSEL_RST     32'h00000000
`define GPE_RESP_OKAY      2'h0
`define GPE_RESP_SLVERR    2'h2

// ****************************************
// Timing
// ****************************************
`define GPE_CLK_PERIOD_NS  10
`define GPE_SYNC_STAGES    3

`endif

/* File: common/gpe_pkg.sv */
package gpe_pkg;
	typedef enum logic [1:0] {GPE_TRIG_RISE, GPE_TRIG_FALL, GPE_TRIG_BOTH, GPE_TRIG_HIGH} gpe_trig_t;
	typedef enum {GPE_RD_IDLE, GPE_RD_RESP} gpe_rd_state_t;
	typedef enum {GPE_WR_IDLE, GPE_WR_RESP} gpe_wr_state_t;
endpackage

/* File: src/gpe_sync.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gpe_params.svh"

module gpe_sync #(
	parameter int WIDTH = 64
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	// Pin side
	input  wire logic [WIDTH-1:0] pin_in,
	// Clean side
	output logic      [WIDTH-1:0] level
);
	logic [WIDTH-1:0] s1_r, s2_r, s3_r, level_r;
	logic [WIDTH-1:0] s1_nxt, s2_nxt, s3_nxt, level_nxt;

	initial begin
		if (WIDTH < 1) $error("gpe_sync: WIDTH must be positive");
	end

	// A change is accepted once the second and third stages agree
	always_comb begin
		s1_nxt    = s1_r;
		s2_nxt    = s2_r;
		s3_nxt    = s3_r;
		level_nxt = level_r;
		if (ce) begin
			s1_nxt    = pin_in;
			s2_nxt    = s1_r;
			s3_nxt    = s2_r;
			level_nxt = (s2_r & s3_r) | (level_r & (s2_r | s3_r));
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r    <= '0;
			s2_r    <= '0;
			s3_r    <= '0;
			level_r <= '0;
		end else begin
			s1_r    <= s1_nxt;
			s2_r    <= s2_nxt;
			s3_r    <= s3_nxt;
			level_r <= level_nxt;
		end
	end

	assign level = level_r;
endmodule

`default_nettype wire

/* File: test/gpe_port_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bus, pin mux and interrupt checks
// ****************
module gpe_port_asserts #(
	parameter int N_LINES = 64
) (
	// Clock and control
	input wire logic               REF_CLK,
	input wire logic               RESETN,
	input wire logic               CE,
	// Bus handshakes
	input wire logic               AWVALID,
	input wire logic               AWREADY,
	input wire logic               WVALID,
	input wire logic               WREADY,
	input wire logic               BVALID,
	input wire logic               ARVALID,
	input wire logic               ARREADY,
	input wire logic               RVALID,
	input wire logic               RREADY,
	// Pins and mux
	input wire logic [N_LINES-1:0] GPIO_OUT,
	input wire logic [N_LINES-1:0] GPIO_OE,
	input wire logic [N_LINES-1:0] ALT_OUT,
	input wire logic [N_LINES-1:0] ALT_OE,
	input wire logic [N_LINES-1:0] ALT_IN,
	input wire logic [N_LINES-1:0] PIN_SEL_ALT,
	// Interrupts
	input wire logic               CPU_INTERRUPT,
	input wire logic               POWER_UNIT_INTERRUPT
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);

	irq_pair_a: assert property (CPU_INTERRUPT == POWER_UNIT_INTERRUPT)
		else $error("interrupt outputs differ");
	ded_sel_a: assert property (PIN_SEL_ALT[15:0] == 16'h0000)
		else $error("dedicated line selected for alternate use");
	alt_mux_a: assert property (&(~PIN_SEL_ALT | ~(GPIO_OE ^ ALT_OE | GPIO_OUT ^ ALT_OUT)))
		else $error("alternate drive not routed to pin");
	alt_gate_a: assert property ((ALT_IN & ~PIN_SEL_ALT) == '0)
		else $error("alternate input leaks on general line");
	rd_answer_a: assert property (ARVALID && ARREADY && CE |=> RVALID)
		else $error("read answer late");
	rd_done_a: assert property (RVALID && RREADY && CE |=> !RVALID)
		else $error("read answer repeated");
	rd_block_a: assert property (RVALID |-> !ARREADY)
		else $error("read accepted while answer pending");
	wr_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY && CE ##1 CE
		|-> ##1 BVALID)
		else $error("write answer late");
	wr_block_a: assert property (BVALID |-> !AWREADY && !WREADY)
		else $error("write accepted while answer pending");
endmodule

bind gpe_port gpe_port_asserts #(.N_LINES(N_LINES)) chk_u (
	.REF_CLK(REF_CLK), .RESETN(RESETN), .CE(CE), .AWVALID(AWVALID), .AWREADY(AWREADY),
	.WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .ARVALID(ARVALID),
	.ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .GPIO_OUT(GPIO_OUT),
	.GPIO_OE(GPIO_OE), .ALT_OUT(ALT_OUT), .ALT_OE(ALT_OE), .ALT_IN(ALT_IN),
	.PIN_SEL_ALT(PIN_SEL_ALT), .CPU_INTERRUPT(CPU_INTERRUPT),
	.POWER_UNIT_INTERRUPT(POWER_UNIT_INTERRUPT));
`default_nettype wire

/* File: test/gpe_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Board pins: port drive, outside drivers, pads
// ****************
module gpe_pin_model (
	// Clock
	input wire logic          clk,
	// Port and outside drivers
	input wire logic [63:0]   oe,
	input wire logic [63:0]   out,
	input wire logic [63:0]   drv,
	input wire logic [63:0]   drv_en,
	input wire logic [383:0]  pad,
	// Wire level
	output logic [63:0]       lvl
);
	logic t_r = 1'b0;

	always @(posedge clk) begin
		t_r <= ~t_r;
	end

	// A floating pin toggles so a stale value is never mistaken for a read
	always_comb begin
		for (int i = 0; i < 64; i++) begin
			lvl[i] = oe[i] ? out[i] : drv_en[i] ? drv[i] : pad[6*i+2] ? pad[6*i+3] : t_r;
		end
	end
endmodule
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gpe_params.svh"
module tb;
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	logic         ce = 1'b1;
	logic [11:0]  awaddr = 12'h000;
	logic [11:0]  araddr = 12'h000;
	logic [31:0]  wdata = 32'h0;
	logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic         awready, wready, bvalid, arready, rvalid, irq_cpu, irq_pwr;
	logic [1:0]   bresp, rresp, rsp;
	logic [31:0]  rdata, rd;
	logic [63:0]  pin_lvl, gp_out, gp_oe, alt_in, sel_alt, eo, eu, ex;
	logic [63:0]  alt_out = '0, alt_oe = '0, drv = 64'h3C5A96F00F69A400;
	logic [63:0]  drv_en = 64'h0000FFFFFFFFFFFF;
	logic [383:0] pad_cfg;
	int           fail_count = 0, n_compared = 0, cyc = 0;

	always #5 clk = ~clk;

	gpe_port dut_u (.REF_CLK(clk), .RESETN(rst_n), .CE(ce), .AWADDR(awaddr),
		.AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid),
		.WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
		.ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
		.RREADY(rready), .GPIO_IN(pin_lvl), .GPIO_OUT(gp_out), .GPIO_OE(gp_oe),
		.ALT_OUT(alt_out), .ALT_OE(alt_oe), .ALT_IN(alt_in), .PIN_SEL_ALT(sel_alt),
		.PAD_CFG(pad_cfg), .CPU_INTERRUPT(irq_cpu), .POWER_UNIT_INTERRUPT(irq_pwr));
	gpe_pin_model pins_u (.clk(clk), .oe(gp_oe), .out(gp_out), .drv(drv), .drv_en(drv_en),
		.pad(pad_cfg), .lvl(pin_lvl));

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			stop_test();
		end
	end

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(negedge clk);
			ad = ad | awready;
			wd = wd | wready;
			@(posedge clk);
			if (ad) awvalid <= 1'b0;
			if (wd) wvalid <= 1'b0;
		end
		do @(negedge clk); while (!bvalid);
		r = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask

	task automatic rd_reg(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge clk); while (!arready);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (!rvalid);
		d = rdata;
		r = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask

	// Response code travels with the data so one compare covers both
	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		rd_reg(a, rd, rsp);
		chk(nm, {30'h0, rsp, rd}, {30'h0, `GPE_RESP_OKAY, e});
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rchk("oe reset", `GPE_OFS_OE_LO, 32'h0);
		rchk("pad reset", `GPE_OFS_PAD_BASE, 32'h4);
		chk("pad port reset", pad_cfg[5:0], 6'h04);
		wr(`GPE_OFS_IRQ_MASK, 32'hFF, rsp);
		for (int m = 0; m < 4; m++) begin
			wr(`GPE_OFS_RISE_EN, {31'h0, m == 0 || m == 2} << m, rsp);
			wr(`GPE_OFS_FALL_EN, {31'h0, m == 1 || m == 2} << m, rsp);
			wr(`GPE_OFS_LEVEL_EN, {31'h0, m == 3} << m, rsp);
			rd_reg(`GPE_OFS_IRQ_STAT, rd, rsp);
			drv[m] <= 1'b1;
			repeat (8) @(posedge clk);
			chk("irq rise", irq_cpu, m != 1);
			rchk("stat rise", `GPE_OFS_IRQ_STAT, {31'h0, m != 1} << m);
			repeat (3) @(posedge clk);
			chk("irq level", irq_cpu, m == 3);
			drv[m] <= 1'b0;
			repeat (8) @(posedge clk);
			chk("irq fall", irq_cpu, m != 0);
			rd_reg(`GPE_OFS_IRQ_STAT, rd, rsp);
			repeat (3) @(posedge clk);
			chk("irq clear", irq_cpu, 1'b0);
		end
		wr(`GPE_OFS_LEVEL_EN, 32'h0, rsp);
		wr(`GPE_OFS_RISE_EN, 32'hFF, rsp);
		wr(`GPE_OFS_IRQ_MASK, 32'h0, rsp);
		drv[0] <= 1'b1;
		drv[8] <= 1'b1;
		repeat (8) @(posedge clk);
		chk("irq masked", irq_cpu, 1'b0);
		wr(`GPE_OFS_IRQ_MASK, 32'hFF, rsp);
		repeat (3) @(posedge clk);
		chk("irq unmasked", irq_cpu, 1'b1);
		chk("irq pwr", irq_pwr, 1'b1);
		rchk("stat line8", `GPE_OFS_IRQ_STAT, 32'h1);
		drv[8:0] <= 9'h000;
		// Clock enable low must freeze the synchroniser and the status bits
		repeat (8) @(posedge clk);
		ce <= 1'b0;
		drv[0] <= 1'b1;
		repeat (8) @(posedge clk);
		chk("ce frozen", irq_cpu, 1'b0);
		ce <= 1'b1;
		repeat (8) @(posedge clk);
		chk("ce resumed", irq_cpu, 1'b1);
		rd_reg(`GPE_OFS_IRQ_STAT, rd, rsp);
		drv[0] <= 1'b0;
		// Lines 0..8 stay inputs so the interrupt pins are never driven
		wr(`GPE_OFS_OUT_LO, 32'hA5C20F96, rsp);
		wr(`GPE_OFS_OUT_HI, 32'h5A3CF069, rsp);
		wr(`GPE_OFS_OE_LO, 32'hFFFEFE00, rsp);
		wr(`GPE_OFS_OE_HI, 32'h00FFFF0F, rsp);
		wr(`GPE_OFS_PAD_BASE + 12'h0FC, 32'h0C, rsp);
		wr(`GPE_OFS_PINSEL_HI, 32'h1, rsp);
		alt_oe <= 64'h10000;
		alt_out <= 64'h10000;
		eo = {32'h00FFFF0F, 32'hFFFFFE00};
		eu = {32'h5A3CF069, 32'hA5C30F96};
		ex = (eo & eu) | (~eo & drv_en & drv) | (~eo & ~drv_en & 64'h8000000000000000);
		repeat (8) @(posedge clk);
		chk("oe", gp_oe, eo);
		chk("out", gp_out, eu);
		chk("pin select", sel_alt, 64'h10000);
		chk("pad63", pad_cfg[383:378], 6'h0C);
		chk("alt in", alt_in, 64'h10000);
		rchk("in lo", `GPE_OFS_IN_LO, ex[31:0]);
		rchk("in hi", `GPE_OFS_IN_HI, ex[63:32]);
		rchk("pinsel", `GPE_OFS_PINSEL_HI, 32'h1);
		wr(12'h140, 32'h1, rsp);
		chk("unmapped wr", rsp, `GPE_RESP_SLVERR);
		rd_reg(12'h030, rd, rsp);
		chk("unmapped rd", rsp, `GPE_RESP_SLVERR);
		stop_test();
	end
endmodule
`default_nettype wire
